// >>> design/tpl_linearizer.sv
// Purpose: ten point linearizer, maps a sample through a curve plus offset
// Assumes: upstream and downstream use valid/ready; apb slave, zero wait
// Notes:   a serial divider does the interpolation, one quotient bit a cycle
//
// Notes on behaviour
// - interpolated, input at or below point 1 gives output point 1
// - interpolated, input equal to input point k gives output point k
// - interpolated, between points, linear along the neighbouring segment
// - the offset is added after scaling in every mode
// - points and offset are signed, full range, three decimal digits
// - stepped, input below input point 2 gives output point 1
// - stepped, input in [point k, point k+1) gives output point k
// - stepped, input at or above input point 10 gives output point 10
// - function selects off, stepped or interpolated
// - function off passes the input plus the offset
// - a configured units tag goes with the output
// - an input error is forwarded unchanged with the output
module tpl_linearizer
  import tpl_pkg::*;
#(
  parameter int unsigned NPTS = TPL_NPTS
) (
  input  wire logic                 CLOCK,
  input  wire logic                 RSTN,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [7:0]           PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 IN_VALID,
  output logic                      IN_READY,
  input  wire tpl_pkg::tpl_sample_t IN_DATA,
  output logic                      OUT_VALID,
  input  wire logic                 OUT_READY,
  output tpl_pkg::tpl_sample_t      OUT_DATA
);
  import tpl_pkg::*;

  initial begin
    if (NPTS != TPL_NPTS) $error("tpl_linearizer serves ten points only");
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic signed [31:0] inpt_q [NPTS];
  logic signed [31:0] inpt_d [NPTS];
  logic signed [31:0] outpt_q [NPTS];
  logic signed [31:0] outpt_d [NPTS];
  logic signed [31:0] offset_q, offset_d;
  logic [1:0]         func_q, func_d;
  logic [2:0]         unit_q, unit_d;
  logic [31:0]        prdata_d;
  logic               pslverr_d;
  logic               busy_q;
  logic [31:0]        cnt_q;

  wire apb_acc = PSEL && PENABLE;
  wire apb_wr  = apb_acc && PWRITE;
  wire [3:0] pidx = PADDR[5:2];

  // clamp a written value into the documented range
  function automatic logic signed [31:0] clamp(input logic signed [31:0] v);
    if (v > TPL_VAL_MAX) return TPL_VAL_MAX;
    else if (v < TPL_VAL_MIN) return TPL_VAL_MIN;
    else return v;
  endfunction

  // decode of reads in setup (data stands in access), writes in access
  always_comb begin
    offset_d  = offset_q;
    func_d    = func_q;
    unit_d    = unit_q;
    prdata_d  = 32'h0;
    pslverr_d = 1'b0;
    for (int i = 0; i < NPTS; i++) begin
      inpt_d[i]  = inpt_q[i];
      outpt_d[i] = outpt_q[i];
    end
    if (PSEL) begin
      if (PADDR == TPL_OFF_CTRL) begin
        prdata_d = {27'h0, unit_q, func_q};
        if (apb_wr) begin
          func_d = PWDATA[1:0];
          unit_d = PWDATA[4:2];
        end
      end else if (PADDR == TPL_OFF_OFFSET) begin
        prdata_d = offset_q;
        if (apb_wr) offset_d = clamp(PWDATA);
      end else if (PADDR == TPL_OFF_STATUS) begin
        prdata_d = {30'h0, OUT_VALID, busy_q};
      end else if ((PADDR & 8'hc3) == TPL_OFF_INPT && pidx < 4'(NPTS)) begin
        prdata_d = inpt_q[pidx];
        if (apb_wr) inpt_d[pidx] = clamp(PWDATA);
      end else if ((PADDR & 8'hc3) == TPL_OFF_OUTPT && pidx < 4'(NPTS)) begin
        prdata_d = outpt_q[pidx];
        if (apb_wr) outpt_d[pidx] = clamp(PWDATA);
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  // configuration storage
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      offset_q <= 32'h0;
      func_q   <= TPL_FUNC_RST;
      unit_q   <= TPL_UNIT_RST;
      PRDATA   <= 32'h0;
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      for (int i = 0; i < NPTS; i++) begin
        inpt_q[i]  <= 32'h0;
        outpt_q[i] <= 32'h0;
      end
    end else begin
      offset_q <= offset_d;
      func_q   <= func_d;
      unit_q   <= unit_d;
      PRDATA   <= prdata_d;
      PREADY   <= PSEL && !PENABLE;   // no wait state, ready in the first access cycle
      PSLVERR  <= PSEL && !PENABLE && 1'b0;
      for (int i = 0; i < NPTS; i++) begin
        inpt_q[i]  <= inpt_d[i];
        outpt_q[i] <= outpt_d[i];
      end
    end
  end

  // ****************************************************************
  // scaling engine
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_DONE} tpl_state_t;
  tpl_state_t st_q, st_d;
  tpl_sample_t smp_q, smp_d;
  logic signed [63:0] num_q, num_d;     // remainder magnitude
  logic [63:0]        den_q, den_d;
  logic [31:0]        quo_q, quo_d;
  logic [5:0]         bit_q, bit_d;
  logic               neg_q, neg_d;
  logic signed [31:0] base_q, base_d;
  logic signed [31:0] res_q, res_d;
  logic               busy_d;
  logic               push;
  logic               buf_ready;

  // segment search on the incoming value
  logic [3:0] seg;     // highest k (0 based) with in >= inpt[k]
  logic       below;   // input at or below point 1
  always_comb begin
    seg   = 4'h0;
    below = (IN_DATA.value <= inpt_q[0]);
    for (int k = 1; k < NPTS; k++) begin
      if (IN_DATA.value >= inpt_q[k]) seg = 4'(k);
    end
  end

  wire signed [32:0] dx = 33'(IN_DATA.value) - 33'(inpt_q[seg]);
  wire signed [32:0] span = 33'(inpt_q[seg+4'h1]) - 33'(inpt_q[seg]);
  wire signed [32:0] dy = 33'(outpt_q[seg+4'h1]) - 33'(outpt_q[seg]);
  wire signed [65:0] prod = 66'(dx) * 66'(dy);
  wire signed [32:0] sum = 33'(res_q) + 33'(offset_q);

  // take a sample, resolve direct cases, else run the divider
  always_comb begin
    st_d   = st_q;
    smp_d  = smp_q;
    num_d  = num_q;
    den_d  = den_q;
    quo_d  = quo_q;
    bit_d  = bit_q;
    neg_d  = neg_q;
    base_d = base_q;
    res_d  = res_q;
    push   = 1'b0;
    unique case (st_q)
      S_IDLE: begin
        if (IN_VALID && IN_READY) begin
          smp_d = IN_DATA;
          st_d  = S_DONE;
          if (unit_q != TPL_UNIT_SOURCE) smp_d.units = unit_q;
          if (func_q == TPL_FUNC_STEP) begin
            res_d = outpt_q[seg];
          end else if (func_q == TPL_FUNC_INTERP) begin
            if (below) res_d = outpt_q[0];
            else if (seg == 4'(NPTS - 1) || span == 33'sh0 ||
                     dx == 33'sh0) begin
              res_d = outpt_q[seg];
            end else begin
              base_d = outpt_q[seg];
              neg_d  = prod[65];
              num_d  = prod[65] ? 64'(-prod) : 64'(prod);
              den_d  = 64'(span);
              quo_d  = 32'h0;
              bit_d  = 6'd31;
              st_d   = S_DIV;
            end
          end else begin
            res_d = IN_DATA.value;
          end
        end
      end
      S_DIV: begin
        // restoring division, one quotient bit per cycle
        if (64'(num_q) >= (den_q << bit_q)) begin
          num_d = num_q - 64'(den_q << bit_q);
          quo_d = quo_q | (32'h1 << bit_q);
        end
        bit_d = bit_q - 6'd1;
        if (bit_q == 6'd0) begin
          res_d = base_q + (neg_q ? -$signed(quo_d) : $signed(quo_d));
          st_d  = S_DONE;
        end
      end
      S_DONE: begin
        if (buf_ready) begin
          push = 1'b1;
          st_d = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    busy_d = (st_d != S_IDLE);
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      st_q   <= S_IDLE;
      smp_q  <= '0;
      num_q  <= 64'h0;
      den_q  <= 64'h0;
      quo_q  <= 32'h0;
      bit_q  <= 6'h0;
      neg_q  <= 1'b0;
      base_q <= 32'h0;
      res_q  <= 32'h0;
      busy_q <= 1'b0;
      IN_READY <= 1'b0;
    end else begin
      st_q   <= st_d;
      smp_q  <= smp_d;
      num_q  <= num_d;
      den_q  <= den_d;
      quo_q  <= quo_d;
      bit_q  <= bit_d;
      neg_q  <= neg_d;
      base_q <= base_d;
      res_q  <= res_d;
      busy_q <= busy_d;
      IN_READY <= (st_d == S_IDLE);  // take only when idle next cycle
    end
  end

  // ****************************************************************
  // two entry output buffer
  // ****************************************************************
  tpl_sample_t buf_q [2];
  tpl_sample_t buf_d [2];
  tpl_sample_t push_smp;
  logic [1:0]  cnt_b_q, cnt_b_d;

  always_comb begin
    push_smp       = smp_q;
    push_smp.value = (sum > 33'(TPL_VAL_MAX)) ? TPL_VAL_MAX :
                     (sum < 33'(TPL_VAL_MIN)) ? TPL_VAL_MIN :
                     sum[31:0];
  end

  assign buf_ready = (cnt_b_q != 2'd2);

  // shift style buffer: entry 0 is the head
  always_comb begin
    logic pop;
    pop      = OUT_VALID && OUT_READY;
    buf_d[0] = buf_q[0];
    buf_d[1] = buf_q[1];
    cnt_b_d  = cnt_b_q;
    if (pop) begin
      buf_d[0] = buf_q[1];
      cnt_b_d  = cnt_b_d - 2'd1;
    end
    if (push) begin
      buf_d[cnt_b_d[0]] = push_smp;
      cnt_b_d = cnt_b_d + 2'd1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      buf_q[0]  <= '0;
      buf_q[1]  <= '0;
      cnt_b_q   <= 2'd0;
      OUT_VALID <= 1'b0;
      OUT_DATA  <= '0;
    end else begin
      buf_q[0]  <= buf_d[0];
      buf_q[1]  <= buf_d[1];
      cnt_b_q   <= cnt_b_d;
      OUT_VALID <= (cnt_b_d != 2'd0);
      OUT_DATA  <= buf_d[0];
    end
  end

  assign cnt_q = 32'(cnt_b_q);

endmodule

// >>> design/tpl_pkg.sv
// Purpose: shared constants and types for the ten point linearizer
// Assumes: values are signed fixed point with three decimal fractional digits
// Notes:   register offsets are byte addresses on the apb port
package tpl_pkg;

  // ****************************************************************
  // value format
  // ****************************************************************
  localparam int unsigned TPL_VAL_W   = 32;
  localparam int unsigned TPL_NPTS    = 10;
  localparam int unsigned TPL_ERR_W   = 8;
  // full range is +/- 99999.000 held as thousandths
  localparam logic signed [31:0] TPL_VAL_MAX = 32'sd99999000;
  localparam logic signed [31:0] TPL_VAL_MIN = -32'sd99999000;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] TPL_OFF_CTRL   = 8'h00;
  localparam logic [7:0] TPL_OFF_OFFSET = 8'h04;
  localparam logic [7:0] TPL_OFF_STATUS = 8'h08;
  localparam logic [7:0] TPL_OFF_INPT   = 8'h40;
  localparam logic [7:0] TPL_OFF_OUTPT  = 8'h80;
  localparam logic [1:0] TPL_FUNC_RST   = 2'h0;
  localparam logic [2:0] TPL_UNIT_RST   = 3'h0;
  localparam int unsigned TPL_DIV_W     = 5;

  typedef enum logic [1:0] {
    TPL_FUNC_OFF    = 2'h0,
    TPL_FUNC_INTERP = 2'h1,
    TPL_FUNC_STEP   = 2'h2
  } tpl_func_t;

  typedef enum logic [2:0] {
    TPL_UNIT_SOURCE   = 3'h0,
    TPL_UNIT_NONE     = 3'h1,
    TPL_UNIT_ABS_TEMP = 3'h2,
    TPL_UNIT_REL_TEMP = 3'h3,
    TPL_UNIT_POWER    = 3'h4,
    TPL_UNIT_PROCESS  = 3'h5,
    TPL_UNIT_REL_HUM  = 3'h6
  } tpl_unit_t;

  // one analog sample with its error status and units
  typedef struct packed {
    logic signed [31:0] value;
    logic [7:0]         err;
    logic [2:0]         units;
  } tpl_sample_t;

endpackage

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the ten point linearizer
// Assumes: in points 1000 apart, out points 3000 apart, offset -250
// Notes:   results are collected by the sink into a queue
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tpl_pkg::*;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
  logic        clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, in_valid, in_ready, out_valid, out_ready, ack, rx_v;
  logic        go = 0, hold = 0, slow = 0;
  tpl_sample_t tx_d = '0, in_data, out_data, rx_d, rxq [$];
  int          errors = 0, samples_checked = 0, cyc = 0;
  tpl_linearizer tpl_linearizer_i (.CLOCK(clock), .RSTN(rstn), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .IN_VALID(in_valid),
    .IN_READY(in_ready), .IN_DATA(in_data), .OUT_VALID(out_valid),
    .OUT_READY(out_ready), .OUT_DATA(out_data));
  tpl_partner tpl_partner_i (.clock(clock), .go(go), .tx_d(tx_d), .ack(ack),
    .hold(hold), .slow(slow), .rx_v(rx_v), .rx_d(rx_d), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  // clock, result collection and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    if (rx_v === 1'b1) rxq.push_back(rx_d);
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] xo(int k);
    return 32'((k - 1) * 3000 - 6250);
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clock);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic send(logic [31:0] v, logic [7:0] e, logic [2:0] u,
                      output logic ok);
    @(posedge clock);
    tx_d <= '{v, e, u};
    go   <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 100 && !ok; i++) begin
      @(posedge clock);
      ok = (ack === 1'b1);
    end
  endtask
  task automatic run(string n, logic [31:0] v, logic [7:0] e,
                     logic [2:0] u, logic [31:0] xv, logic [2:0] xu);
    logic        ok;
    tpl_sample_t s;
    send(v, e, u, ok);
    wait (rxq.size() > 0);
    s = rxq.pop_front();
    `CHK(n, xv, s.value)
    `CHK(n, e, s.err)
    `CHK(n, xu, s.units)
  endtask
  task automatic t_regs();
    logic [31:0] r;
    apb(1'b0, TPL_OFF_CTRL, '0, r);
    `CHK("ctrl reset", 32'h0, r)
    apb(1'b0, 8'h3c, '0, r);
    `CHK("unmapped", 32'h0, r)
    for (int i = 0; i < 10; i++) begin
      wr(TPL_OFF_INPT + 8'(4 * i), 32'((i + 1) * 1000));
      wr(TPL_OFF_OUTPT + 8'(4 * i), 32'(i * 3000 - 6000));
    end
    wr(TPL_OFF_OFFSET, 32'hffffff06);
    apb(1'b0, TPL_OFF_OFFSET, '0, r);
    `CHK("offset", 32'hffffff06, r)
    apb(1'b0, TPL_OFF_OUTPT, '0, r);
    `CHK("out point 1", 32'hffffe890, r)
    $display("test regs done");
  endtask
  task automatic t_interp();
    wr(TPL_OFF_CTRL, 32'h1);
    run("below p1", 32'hffffec78, 8'h0, 3'h2, xo(1), 3'h2);
    run("at p1", 32'h3e8, 8'h0, 3'h2, xo(1), 3'h2);
    run("at p5", 32'h1388, 8'h0, 3'h2, xo(5), 3'h2);
    run("at p10", 32'h2710, 8'h0, 3'h2, xo(10), 3'h2);
    run("p2 p3", 32'h9c4, 8'h0, 3'h2, 32'hfffff92a, 3'h2);
    run("p7 p8", 32'h1c52, 8'h0, 3'h2, 32'h30d4, 3'h2);
    run("above p10", 32'hc350, 8'h0, 3'h2, xo(10), 3'h2);
    $display("test interp done");
  endtask
  task automatic t_step();
    wr(TPL_OFF_CTRL, 32'h2);
    run("below p2", 32'h7cf, 8'h0, 3'h6, xo(1), 3'h6);
    run("at p2", 32'h7d0, 8'h0, 3'h6, xo(2), 3'h6);
    run("below p10", 32'h270f, 8'h5a, 3'h6, xo(9), 3'h6);
    run("at p10", 32'h2710, 8'h0, 3'h6, xo(10), 3'h6);
    $display("test step done");
  endtask
  task automatic t_units();
    for (int u = 0; u < 7; u++) begin
      wr(TPL_OFF_CTRL, 32'(u * 4));
      run("units", 32'h3039, 8'h0, 3'h5, 32'h2f3f, (u == 0) ? 3'h5 : 3'(u));
    end
    $display("test units done");
  endtask
  task automatic t_buffer();
    logic        ok;
    tpl_sample_t s;
    wr(TPL_OFF_CTRL, 32'h0);
    hold <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(32'(i), 8'h0, 3'h1, ok);
      `CHK("taken while stalled", i < 3, ok)
    end
    {hold, slow} <= 2'b01;
    wait (rxq.size() == 4);
    for (int i = 0; i < 4; i++) begin
      s = rxq.pop_front();
      `CHK("drain order", 32'(i - 250), s.value)
    end
    $display("test buffer done");
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_interp();
    t_step();
    t_units();
    t_buffer();
    end_sim();
  end
endmodule

// >>> sim/tpl_assertions.sv
// Purpose: port checker for the ten point linearizer
// Assumes: config is left alone while a sample is in flight
// Notes:   shadows a few registers from apb writes
module tpl_assertions
  import tpl_pkg::*;
(
  input wire logic                 CLOCK,
  input wire logic                 RSTN,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [7:0]           PADDR,
  input wire logic [31:0]          PWDATA,
  input wire logic                 PREADY,
  input wire logic                 IN_VALID,
  input wire logic                 IN_READY,
  input wire tpl_pkg::tpl_sample_t IN_DATA,
  input wire logic                 OUT_VALID,
  input wire logic                 OUT_READY,
  input wire tpl_pkg::tpl_sample_t OUT_DATA
);
  // ctrl, offset, in point 1, 2, 10, out point 1, 10
  localparam logic [7:0] AD [7] = '{8'h00, 8'h04, 8'h40, 8'h44, 8'h64,
                                    8'h80, 8'ha4};
  logic signed [31:0] sh_q [7];
  logic signed [31:0] sh_d [7];
  tpl_sample_t        cap_q;
  tpl_sample_t        cap_d;
  logic [1:0]         cnt_q;
  logic [1:0]         cnt_d;
  // shadow writes, last taken sample, samples in flight
  always_comb begin
    sh_d  = sh_q;
    cap_d = (IN_VALID && IN_READY) ? IN_DATA : cap_q;
    cnt_d = cnt_q + 2'(IN_VALID && IN_READY) - 2'(OUT_VALID && OUT_READY);
    for (int i = 0; i < 7; i++) begin
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == AD[i]) begin
        sh_d[i] = PWDATA;
      end
    end
  end
  // registers the helper state
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      sh_q  <= '{default: '0};
      cap_q <= '0;
      cnt_q <= '0;
    end else begin
      sh_q  <= sh_d;
      cap_q <= cap_d;
      cnt_q <= cnt_d;
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  // a result leaves while it is the only sample in flight
  sequence s_push;
    OUT_VALID && OUT_READY && cnt_q == 2'd1;
  endsequence
  a_interp_low: assert property (s_push ##0 (sh_q[0][1:0] == 2'h1
    && cap_q.value <= sh_q[2]) |-> OUT_DATA.value == sh_q[5] + sh_q[1])
    else $error("low interp input off point 1");
  a_interp_high: assert property (s_push ##0 (sh_q[0][1:0] == 2'h1
    && cap_q.value > sh_q[4]) |-> OUT_DATA.value == sh_q[6] + sh_q[1])
    else $error("high interp input off point 10");
  a_step_low: assert property (s_push ##0 (sh_q[0][1:0] == 2'h2
    && cap_q.value < sh_q[3]) |-> OUT_DATA.value == sh_q[5] + sh_q[1])
    else $error("low step input off point 1");
  a_step_high: assert property (s_push ##0 (sh_q[0][1:0] == 2'h2
    && cap_q.value >= sh_q[4]) |-> OUT_DATA.value == sh_q[6] + sh_q[1])
    else $error("high step input off point 10");
  a_off_bypass: assert property (s_push ##0 sh_q[0][1] == 1'b0
    && sh_q[0][0] == 1'b0 |-> OUT_DATA.value == cap_q.value + sh_q[1])
    else $error("off mode not input plus offset");
  a_units_tag: assert property (s_push |-> OUT_DATA.units ==
    (sh_q[0][4:2] == 3'h0 ? cap_q.units : sh_q[0][4:2]))
    else $error("units tag wrong");
  a_err_pass: assert property (s_push |-> OUT_DATA.err == cap_q.err)
    else $error("error status not forwarded");
  a_out_hold: assert property (OUT_VALID && !OUT_READY
    |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output changed while stalled");
endmodule
bind tpl_linearizer tpl_assertions tpl_assertions_i (
  .CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_DATA(IN_DATA),
  .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA)
);

// >>> sim/tpl_partner.sv
// Purpose: upstream source and downstream sink around the linearizer
// Assumes: one sample is offered per go pulse
// Notes:   the released input bus shows the inverted last sample
module tpl_partner
  import tpl_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 go,
  input  wire tpl_pkg::tpl_sample_t tx_d,
  output logic                      ack,
  input  wire logic                 hold,
  input  wire logic                 slow,
  output logic                      rx_v,
  output tpl_pkg::tpl_sample_t      rx_d,
  output logic                      in_valid,
  input  wire logic                 in_ready,
  output tpl_pkg::tpl_sample_t      in_data,
  input  wire logic                 out_valid,
  output logic                      out_ready,
  input  wire tpl_pkg::tpl_sample_t out_data
);
  logic [1:0] tick;
  initial begin
    {tick, ack, rx_v, in_valid, out_ready} = '0;
    rx_d    = '0;
    in_data = '0;
  end
  // source holds a sample until taken; sink stalls on hold or slow
  always @(posedge clock) begin
    ack       <= 1'b0;
    tick      <= tick + 2'd1;
    out_ready <= !hold && (!slow || tick == 2'd0);
    rx_v      <= out_valid && out_ready;
    rx_d      <= out_data;
    if (go) begin
      in_valid <= 1'b1;
      in_data  <= tx_d;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'b0;
      in_data  <= ~in_data;
      ack      <= 1'b1;
    end
  end
endmodule
